// [rtl/bcr_charger_regs.v]
/*
 * Command and status register set of a smart battery charger, reached as
 * a slave on the system management bus. Holds the bus slave engine, the
 * mode, current and voltage setpoints, the status word and the battery
 * presence filter.
 * Assumes the bus clock and data pins and the analog comparator results
 * come from outside the clock domain; they are synchronised here. The
 * bus clock must stay well below a quarter of the core clock rate.
 */
`timescale 1ns/1ns
`include "bcr_map.vh"

// Function
// - Answer only slave address 0001001.
// - Read word 0x11 returns specification info.
// - Info reports revision 1.1, no selector.
// - Mode word 0x12 is write only.
// - Hold bit suspends charging, keeps setpoints.
// - Power or battery return clears hold bit.
// - Polling bit and reserved bits ignored.
// - Restore bit returns power-on defaults.
// - Clear bit zeroes both setpoints always.
// - Read word 0x13 returns status word.
// - Status bit 0 mirrors hold bit.
// - Status bits 1 to 3 read zero.
// - Bit 4 reads one, bit 5 zero.
// - Current overrange when above programmed maximum.
// - Voltage overrange at or above maximum.
// - Open flag when sense above 95 kilohm.
// - Cold flag above 28.5 kilohm or open.
// - Hot flag below 3150 ohm or underrange.
// - Underrange flag below 575 ohm.
// - Presence filter; absence zeroes setpoints.
// - Adapter flag; its change raises alert.
// - Write word 0x14 sets current in milliamps.
module bcr_charger_regs #(
    parameter [15:0] CURRENT_MAX   = 16'h0fa0,
    parameter [15:0] VOLTAGE_MAX   = 16'h1068,
    parameter        SAMPLE_CYCLES = `BCR_SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // Management bus pins
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe,
    output reg         alert_o,
    output reg         alert_oe,
    // Comparator results on the battery sense line, raw
    input  wire        sense_open_raw,
    input  wire        sense_cold_raw,
    input  wire        sense_hot_raw,
    input  wire        sense_under_raw,
    // Adapter sense comparator, raw
    input  wire        adapter_sense_input,
    // Charge loop controls
    output reg  [15:0] current_setpoint_q,
    output reg  [15:0] voltage_setpoint_q,
    output reg         charge_enable_q
);

    localparam PH_IDLE = 3'd0;
    localparam PH_RX   = 3'd1;
    localparam PH_ACK  = 3'd2;
    localparam PH_TX   = 3'd3;
    localparam PH_MACK = 3'd4;

    wire [6:0] pins_s;
    reg        scl_p_q;
    reg        sda_p_q;
    reg  [2:0] phase_q;
    reg  [2:0] bit_cnt_q;
    reg  [1:0] byte_idx_q;
    reg  [7:0] shift_q;
    reg  [7:0] cmd_q;
    reg  [7:0] lo_q;
    reg  [7:0] txsh_q;
    reg  [7:0] tx_hi_byte_q;
    reg        rd_q;
    reg        tx_hi_q;
    reg        ack_pend_q;
    reg        hold_q;
    reg        present_q;
    reg  [1:0] good_cnt_q;
    reg [19:0] tick_cnt_q;
    reg        adapter_q;
    reg        open_q;
    reg        cold_q;
    reg        hot_q;
    reg        under_q;
    reg        cur_or_q;
    reg        volt_or_q;

    // The bus pins pass the synchroniser inverted, so that its cleared
    // state reads as an idle bus and no false edge follows reset.
    wire scl_s     = ~pins_s[0];
    wire sda_s     = ~pins_s[1];
    wire open_s    = pins_s[2];
    wire cold_s    = pins_s[3];
    wire hot_s     = pins_s[4];
    wire under_s   = pins_s[5];
    wire adapter_s = pins_s[6];

    wire scl_rise  = scl_s & ~scl_p_q;
    wire scl_fall  = ~scl_s & scl_p_q;
    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire [7:0] rx_byte = {shift_q[6:0], sda_s};
    wire       bus_ev  = ~start_det & ~stop_det;

    // One-cycle strobe when the high data byte of a write completes.
    wire wr_stb = bus_ev & scl_rise & (phase_q == PH_RX) &
                  (bit_cnt_q == 3'd7) & (byte_idx_q == 2'd3) & ~rd_q;
    wire [15:0] wr_word = {rx_byte, lo_q};
    wire mode_wr = wr_stb & (cmd_q == `BCR_CMD_MODE);
    wire restore = mode_wr & wr_word[`BCR_MODE_RESTORE];
    // Status read counts as done once its high byte has been clocked out.
    wire status_rd_done = bus_ev & scl_rise & (phase_q == PH_MACK) &
                          tx_hi_q & (cmd_q == `BCR_CMD_STATUS);
    wire sample_tick = (tick_cnt_q == 20'd0);

    // Read data for a command; unknown and write-only commands read zero.
    function [15:0] read_word;
        input [7:0]  cmd;
        input [15:0] status;
        begin
            case (cmd)
                `BCR_CMD_SPEC_INFO: read_word = `BCR_SPEC_INFO_VALUE;
                `BCR_CMD_STATUS:    read_word = status;
                default:            read_word = 16'h0000;
            endcase
        end
    endfunction

    reg [15:0] status_word;
    always @* begin
        status_word = 16'h0000;
        status_word[`BCR_ST_HOLD]       = hold_q;
        status_word[`BCR_ST_LEVEL2]     = 1'b1;
        status_word[`BCR_ST_CURRENT_OR] = cur_or_q;
        status_word[`BCR_ST_VOLTAGE_OR] = volt_or_q;
        status_word[`BCR_ST_OPEN]       = open_q;
        status_word[`BCR_ST_COLD]       = cold_q;
        status_word[`BCR_ST_HOT]        = hot_q;
        status_word[`BCR_ST_UNDER]      = under_q;
        status_word[`BCR_ST_PRESENT]    = present_q;
        status_word[`BCR_ST_ADAPTER]    = adapter_q;
    end

    wire [15:0] rd_word = read_word(cmd_q, status_word);

    bcr_sync #(
        .WIDTH    (7)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({adapter_sense_input, sense_under_raw, sense_hot_raw,
                    sense_cold_raw, sense_open_raw, ~sda_i, ~scl_i}),
        .sync_out (pins_s)
    );

    // Bus slave engine: bits in on the clock rise, out on the clock fall.
    always @(posedge clock) begin
        if (!rst_n) begin
            scl_p_q      <= 1'b1;
            sda_p_q      <= 1'b1;
            phase_q      <= PH_IDLE;
            bit_cnt_q    <= 3'd0;
            byte_idx_q   <= 2'd0;
            shift_q      <= 8'h00;
            cmd_q        <= 8'h00;
            lo_q         <= 8'h00;
            txsh_q       <= 8'h00;
            tx_hi_byte_q <= 8'h00;
            rd_q         <= 1'b0;
            tx_hi_q      <= 1'b0;
            ack_pend_q   <= 1'b0;
            sda_o        <= 1'b0;
            sda_oe       <= 1'b0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            sda_o   <= 1'b0;
            if (start_det) begin
                // A repeated start keeps the command code for the read.
                phase_q    <= PH_RX;
                bit_cnt_q  <= 3'd0;
                byte_idx_q <= 2'd0;
                ack_pend_q <= 1'b0;
                sda_oe     <= 1'b0;
            end else if (stop_det) begin
                phase_q    <= PH_IDLE;
                ack_pend_q <= 1'b0;
                sda_oe     <= 1'b0;
            end else if (scl_rise) begin
                case (phase_q)
                    PH_RX: begin
                        shift_q   <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            case (byte_idx_q)
                                2'd0: begin
                                    if (rx_byte[7:1] == `BCR_SLAVE_ADDR) begin
                                        ack_pend_q <= 1'b1;
                                        rd_q       <= rx_byte[0];
                                    end else begin
                                        phase_q <= PH_IDLE;
                                    end
                                end
                                2'd1: begin
                                    cmd_q      <= rx_byte;
                                    ack_pend_q <= 1'b1;
                                end
                                2'd2: begin
                                    lo_q       <= rx_byte;
                                    ack_pend_q <= 1'b1;
                                end
                                default: ack_pend_q <= 1'b1;
                            endcase
                        end
                    end
                    PH_TX: begin
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            phase_q <= PH_MACK;
                        end
                    end
                    PH_MACK: begin
                        if (!sda_s && !tx_hi_q) begin
                            txsh_q    <= tx_hi_byte_q;
                            tx_hi_q   <= 1'b1;
                            bit_cnt_q <= 3'd0;
                            phase_q   <= PH_TX;
                        end else begin
                            phase_q <= PH_IDLE;
                        end
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                if (ack_pend_q) begin
                    ack_pend_q <= 1'b0;
                    sda_oe     <= 1'b1;
                    phase_q    <= PH_ACK;
                end else begin
                    case (phase_q)
                        PH_ACK: begin
                            bit_cnt_q <= 3'd0;
                            if (rd_q && byte_idx_q == 2'd0) begin
                                // Word is latched so both bytes agree.
                                phase_q      <= PH_TX;
                                tx_hi_q      <= 1'b0;
                                tx_hi_byte_q <= rd_word[15:8];
                                sda_oe       <= ~rd_word[7];
                                txsh_q       <= {rd_word[6:0], 1'b0};
                            end else begin
                                sda_oe <= 1'b0;
                                if (byte_idx_q == 2'd3) begin
                                    phase_q <= PH_IDLE;
                                end else begin
                                    phase_q    <= PH_RX;
                                    byte_idx_q <= byte_idx_q + 2'd1;
                                end
                            end
                        end
                        PH_TX: begin
                            sda_oe <= ~txsh_q[7];
                            txsh_q <= {txsh_q[6:0], 1'b0};
                        end
                        default: sda_oe <= 1'b0;
                    endcase
                end
            end
        end
    end

    // Charger state; the restore bit acts as a synchronous reset.
    always @(posedge clock) begin
        if (!rst_n || restore) begin
            current_setpoint_q <= `BCR_SETPOINT_RESET;
            voltage_setpoint_q <= `BCR_SETPOINT_RESET;
            hold_q             <= 1'b0;
            present_q          <= 1'b0;
            good_cnt_q         <= 2'd0;
            tick_cnt_q         <= 20'd0;
            adapter_q          <= 1'b0;
            open_q             <= 1'b0;
            cold_q             <= 1'b0;
            hot_q              <= 1'b0;
            under_q            <= 1'b0;
            cur_or_q           <= 1'b0;
            volt_or_q          <= 1'b0;
            charge_enable_q    <= 1'b0;
            alert_o            <= 1'b0;
            alert_oe           <= 1'b0;
        end else begin
            alert_o <= 1'b0;
            if (sample_tick) begin
                tick_cnt_q <= SAMPLE_CYCLES[19:0] - 20'd1;
            end else begin
                tick_cnt_q <= tick_cnt_q - 20'd1;
            end

            open_q    <= open_s;
            cold_q    <= cold_s | open_s;
            hot_q     <= hot_s | under_s;
            under_q   <= under_s;
            adapter_q <= adapter_s;

            // Presence drops at once; it needs two clean samples to rise.
            if (open_s) begin
                present_q  <= 1'b0;
                good_cnt_q <= 2'd0;
            end else if (sample_tick && !present_q) begin
                if (good_cnt_q + 2'd1 == `BCR_PRESENT_SAMPLES) begin
                    present_q <= 1'b1;
                end
                good_cnt_q <= good_cnt_q + 2'd1;
            end

            // Setpoint writes; absence or the clear bit wins over them.
            if (!present_q ||
                (mode_wr && wr_word[`BCR_MODE_CLEAR])) begin
                current_setpoint_q <= 16'h0000;
                voltage_setpoint_q <= 16'h0000;
            end else if (wr_stb && cmd_q == `BCR_CMD_CURRENT) begin
                current_setpoint_q <= wr_word;
            end else if (wr_stb && cmd_q == `BCR_CMD_VOLTAGE) begin
                voltage_setpoint_q <= wr_word;
            end
            cur_or_q  <= current_setpoint_q > CURRENT_MAX;
            volt_or_q <= voltage_setpoint_q >= VOLTAGE_MAX;

            // Only the hold bit is stored; polling and reserved bits drop.
            if ((adapter_s && !adapter_q) ||
                (present_q && good_cnt_q == 2'd0 && open_s) ||
                (!present_q && sample_tick && !open_s &&
                 good_cnt_q + 2'd1 == `BCR_PRESENT_SAMPLES)) begin
                hold_q <= 1'b0;
            end else if (mode_wr) begin
                hold_q <= wr_word[`BCR_MODE_HOLD];
            end

            charge_enable_q <= present_q & adapter_q & ~hold_q & ~hot_q &
                               (current_setpoint_q != 16'h0000) &
                               (voltage_setpoint_q != 16'h0000);

            // A change wins over the clear by a status read.
            if ((adapter_s != adapter_q) || (open_s && present_q) ||
                (!present_q && sample_tick && !open_s &&
                 good_cnt_q + 2'd1 == `BCR_PRESENT_SAMPLES)) begin
                alert_oe <= 1'b1;
            end else if (status_rd_done) begin
                alert_oe <= 1'b0;
            end
        end
    end

endmodule // bcr_charger_regs

// [rtl/bcr_map.vh]
/*
 * Constants of the charger command register set: the slave address,
 * command codes, bit positions of the mode and status words, fixed
 * values and reset values.
 * Assumes it is included by its bare name from the rtl/ folder.
 */
`ifndef BCR_MAP_VH
`define BCR_MAP_VH

// Bus address and command codes.
`define BCR_SLAVE_ADDR      7'h09
`define BCR_CMD_SPEC_INFO   8'h11
`define BCR_CMD_MODE        8'h12
`define BCR_CMD_STATUS      8'h13
`define BCR_CMD_CURRENT     8'h14
`define BCR_CMD_VOLTAGE     8'h15

// Specification info word: revision field reads 1.1, no selector support.
`define BCR_SPEC_INFO_VALUE 16'h0002

// Mode word bit positions.
`define BCR_MODE_HOLD       0
`define BCR_MODE_POLL       1
`define BCR_MODE_RESTORE    2
`define BCR_MODE_CLEAR      3

// Status word bit positions.
`define BCR_ST_HOLD         0
`define BCR_ST_LEVEL2       4
`define BCR_ST_CURRENT_OR   6
`define BCR_ST_VOLTAGE_OR   7
`define BCR_ST_OPEN         8
`define BCR_ST_COLD         9
`define BCR_ST_HOT          10
`define BCR_ST_UNDER        11
`define BCR_ST_PRESENT      14
`define BCR_ST_ADAPTER      15

// Reset values and timing.
`define BCR_SETPOINT_RESET  16'h0000
`define BCR_SAMPLE_CYCLES   1000
`define BCR_PRESENT_SAMPLES 2'd2

`endif

// [rtl/bcr_sync.v]
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level that stays put for several clock cycles;
 * bits are not kept coherent with each other.
 */
`timescale 1ns/1ns
module bcr_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    // The first stage is read by the second stage only.
    always @(posedge clock) begin
        if (!rst_n) begin
            meta_q   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // bcr_sync

// [sim/bcr_host.sv]
/*
 * Bus master model for the charger registers: word writes and word reads.
 * Assumes the bench resolves the open-drain data wire with a pull-up and
 * feeds the level back on sda; the clock idles high between frames.
 */
`timescale 1ns/1ns
module bcr_host (
    // Bus pins
    output logic scl,
    output logic sda_pull,
    input  wire  sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // One bit slot of 160 ns; data only moves while the clock is low.
    task automatic put(input logic b, output logic r);
        sda_pull = !b;
        #40;
        scl = 1'b1;
        #80;
        r = sda;
        scl = 1'b0;
        #40;
    endtask

    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put(d[i], r);
        put(1'b1, r);
        ack = !r;
    endtask

    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put(1'b1, r);
            d[i] = r;
        end
        put(last, r);
    endtask

    // Serves as first and repeated start alike.
    task automatic start();
        sda_pull = 1'b0;
        #40;
        scl = 1'b1;
        #40;
        sda_pull = 1'b1;
        #80;
        scl = 1'b0;
        #40;
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        #40;
        scl = 1'b1;
        #40;
        sda_pull = 1'b0;
        #80;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic [15:0] d, output logic ok);
        logic k0, k1, k2, k3;
        start();
        tx({a, 1'b0}, k0);
        tx(c, k1);
        tx(d[7:0], k2);
        tx(d[15:8], k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] c,
                      output logic [15:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        tx({a, 1'b0}, k0);
        tx(c, k1);
        start();
        tx({a, 1'b1}, k2);
        rx(1'b0, d[7:0]);
        rx(1'b1, d[15:8]);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule // bcr_host

// [sim/bcr_charger_regs_sva.sv]
/*
 * Checker for the charger register set, bound to its top module.
 * Assumes the bus clock half period is far longer than a few core clocks.
 */
`timescale 1ns/1ns
module bcr_charger_regs_sva #(
    parameter [15:0] CURRENT_MAX   = 16'h0fa0,
    parameter [15:0] VOLTAGE_MAX   = 16'h1068,
    parameter        SAMPLE_CYCLES = 1000
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Bus pins
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        alert_o,
    input wire logic        alert_oe,
    // Sense inputs
    input wire logic        sense_open_raw,
    input wire logic        sense_cold_raw,
    input wire logic        sense_hot_raw,
    input wire logic        sense_under_raw,
    input wire logic        adapter_sense_input,
    // Charge loop controls
    input wire logic [15:0] current_setpoint_q,
    input wire logic [15:0] voltage_setpoint_q,
    input wire logic        charge_enable_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // The slave may only move data while the bus clock is low.
    chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data drive changed while bus clock high");
    chk_drive_low: assert property (sda_oe |-> !sda_o)
        else $error("data pin driven high");
    chk_alert_adapter: assert property (
        $changed(adapter_sense_input) |-> ##[1:8] alert_oe)
        else $error("no alert after adapter change");
    chk_alert_drive: assert property (alert_oe |-> !alert_o)
        else $error("alert pin driven high");
    chk_open_idle: assert property (
        sense_open_raw [*5] |-> !charge_enable_q)
        else $error("charging allowed with open sense line");
    chk_open_zero: assert property (sense_open_raw [*5] |->
        current_setpoint_q == 16'h0000 && voltage_setpoint_q == 16'h0000)
        else $error("setpoints kept with open sense line");
    chk_cur_write: assert property (
        $changed(current_setpoint_q) && current_setpoint_q != 16'h0000
        |-> scl_i)
        else $error("current setpoint loaded outside a bit slot");
    chk_volt_write: assert property (
        $changed(voltage_setpoint_q) && voltage_setpoint_q != 16'h0000
        |-> scl_i)
        else $error("voltage setpoint loaded outside a bit slot");

    cover property ($rose(sda_oe));
    cover property ($rose(alert_oe));
    cover property ($changed(current_setpoint_q) && current_setpoint_q != 0);
endmodule // bcr_charger_regs_sva

bind bcr_charger_regs bcr_charger_regs_sva #(
    .CURRENT_MAX(CURRENT_MAX),
    .VOLTAGE_MAX(VOLTAGE_MAX),
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
) chk_i (
    .clock(clock), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
    .alert_oe(alert_oe), .sense_open_raw(sense_open_raw),
    .sense_cold_raw(sense_cold_raw), .sense_hot_raw(sense_hot_raw),
    .sense_under_raw(sense_under_raw),
    .adapter_sense_input(adapter_sense_input),
    .current_setpoint_q(current_setpoint_q),
    .voltage_setpoint_q(voltage_setpoint_q),
    .charge_enable_q(charge_enable_q)
);

// [sim/bcr_charger_regs_test.sv]
/*
 * Self-checking bench of the charger register set with a bus master model.
 * Assumes a 4 ns core clock, a 160 ns bus clock and a short sample period.
 */
`timescale 1ns/1ns
module bcr_charger_regs_test;
    typedef struct packed {
        logic rd; logic chk; logic [7:0] cmd; logic [15:0] val;
    } bcr_row_t;
    logic clock, rst_n, scl, host_pull, ok, so, sc, sh, su, adp;
    logic sda_oe, alert_oe, charge_enable_q;
    logic [15:0] current_setpoint_q, voltage_setpoint_q;
    wire sda = !(host_pull || sda_oe);
    int error_cnt = 0, tests_run = 0, cyc = 0;
    logic [15:0] sexp [3] = '{16'hc210, 16'hc410, 16'hcc10};
    bcr_row_t rows [12] = '{
        '{0,1,8'h14,16'h0123}, '{0,1,8'h15,16'h0456},
        '{1,0,8'h11,16'h0002}, '{1,0,8'h13,16'hc010},
        '{0,0,8'h14,16'h0fa1}, '{1,0,8'h13,16'hc050},
        '{0,1,8'h14,16'h0fa0}, '{1,0,8'h13,16'hc010},
        '{0,0,8'h15,16'h1068}, '{1,0,8'h13,16'hc090},
        '{0,1,8'h15,16'h1067}, '{1,0,8'h30,16'h0000}};

    bcr_host host (.scl(scl), .sda_pull(host_pull), .sda(sda));
    bcr_charger_regs #(.SAMPLE_CYCLES(8)) uut (
        .clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe(sda_oe), .alert_o(), .alert_oe(alert_oe),
        .sense_open_raw(so), .sense_cold_raw(sc), .sense_hot_raw(sh),
        .sense_under_raw(su), .adapter_sense_input(adp),
        .current_setpoint_q(current_setpoint_q),
        .voltage_setpoint_q(voltage_setpoint_q),
        .charge_enable_q(charge_enable_q));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // A hung bus transfer must still end in the closing report.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrc(input logic [7:0] c, input logic [15:0] v);
        host.wr(7'h09, c, v, ok);
        check({15'h0, ok}, 16'h0001);
        repeat (2) @(negedge clock);
    endtask

    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] d;
        host.rd(7'h09, c, d, ok);
        check({15'h0, ok}, 16'h0001);
        check(d, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    initial begin
        {rst_n, so, sc, sh, su} = 5'h00;
        adp = 1'b1;
        repeat (8) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        check(current_setpoint_q | voltage_setpoint_q, 16'h0000);
        check({14'h0, sda_oe, charge_enable_q}, 16'h0000);
        idle(40);
        foreach (rows[i]) begin
            if (rows[i].rd) begin
                rdc(rows[i].cmd, rows[i].val);
            end else begin
                wrc(rows[i].cmd, rows[i].val);
                if (rows[i].chk) check(rows[i].cmd == 8'h14 ?
                    current_setpoint_q : voltage_setpoint_q, rows[i].val);
            end
        end
        host.wr(7'h0a, 8'h14, 16'h0bad, ok);
        check({15'h0, ok}, 16'h0000);
        check(current_setpoint_q, 16'h0fa0);
        wrc(8'h30, 16'h0bad);
        check(current_setpoint_q, 16'h0fa0);
        check(voltage_setpoint_q, 16'h1067);
        wrc(8'h12, 16'hfff3);
        check({15'h0, charge_enable_q}, 16'h0000);
        check(current_setpoint_q, 16'h0fa0);
        rdc(8'h12, 16'h0000);
        rdc(8'h13, 16'hc011);
        wrc(8'h12, 16'h0000);
        check({15'h0, charge_enable_q}, 16'h0001);
        wrc(8'h12, 16'h0009);
        check(current_setpoint_q | voltage_setpoint_q, 16'h0000);
        wrc(8'h14, 16'h0100);
        wrc(8'h12, 16'h0004);
        check(current_setpoint_q, 16'h0000);
        idle(40);
        rdc(8'h13, 16'hc010);
        wrc(8'h14, 16'h0100);
        wrc(8'h12, 16'h0001);
        so = 1'b1;
        idle(10);
        check(current_setpoint_q, 16'h0000);
        host.wr(7'h09, 8'h14, 16'h0200, ok);
        check(current_setpoint_q, 16'h0000);
        rdc(8'h13, 16'h8311);
        so = 1'b0;
        idle(40);
        rdc(8'h13, 16'hc010);
        for (int i = 0; i < 3; i++) begin
            {su, sh, sc} = 3'b001 << i;
            idle(10);
            rdc(8'h13, sexp[i]);
        end
        {su, sh, sc} = 3'b000;
        // A reset in mid-run must drop the setpoints and the alert.
        wrc(8'h14, 16'h0100);
        @(negedge clock) rst_n = 1'b0;
        idle(8);
        rst_n = 1'b1;
        check(current_setpoint_q, 16'h0000);
        check({15'h0, alert_oe}, 16'h0000);
        idle(40);
        rdc(8'h13, 16'hc010);
        adp = 1'b0;
        idle(10);
        check({15'h0, alert_oe}, 16'h0001);
        rdc(8'h13, 16'h4010);
        check({15'h0, alert_oe}, 16'h0000);
        adp = 1'b1;
        idle(20);
        print_verdict();
    end
endmodule // bcr_charger_regs_test
